// ### inc/cfc_defines.svh
// Register offsets, field positions, reset values and limits of the block
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH

`define CFC_OFF_CTRL 12'h000
`define CFC_OFF_TEF 12'h004
`define CFC_OFF_DIAG_HI 12'h008
`define CFC_OFF_DIAG_LO 12'h00C
`define CFC_OFF_FIFO_BASE 12'h010
`define CFC_OFF_STEP 12'h004

`define CFC_CTRL_MODE_LSB 8
`define CFC_CTRL_RTXEN_BIT 0
`define CFC_MODE_CONFIG 3'h4
`define CFC_MODE_RESET 3'h4

`define CFC_FIFO_PL_LSB 13
`define CFC_FIFO_DEP_LSB 8
`define CFC_FIFO_RTX_LSB 5
`define CFC_FIFO_PRI_LSB 0
`define CFC_FIFO_RESET 16'h0060
`define CFC_RTX_RESET 2'h3
`define CFC_RTX_UNLIMITED 2'h3
`define CFC_RTX_THREE 2'h1
`define CFC_RTX_NONE 2'h0
`define CFC_RETRY_COUNT_THREE 2'h3

`define CFC_TEF_DEP_LSB 8
`define CFC_CNT_HI_LSB 8
`define CFC_CNT_MAX 8'hFF
`define CFC_CNT_RESET 8'h00

`endif

// ### inc/cfc_pkg.sv
// Types and shared helpers of the CAN FIFO configuration block
`default_nettype none
package cfc_pkg;

  typedef enum logic {CFC_APB_IDLE, CFC_APB_RESP} cfc_apb_e;

  typedef struct packed {
    cfc_apb_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] opMode;
    logic cfgMode;
    logic retryEn;
    logic [4:0] tefDepthSel;
    logic [5:0] tefSlots;
  } cfc_top_s;

  typedef struct packed {
    logic [2:0] payloadSel;
    logic [4:0] depthSel;
    logic [1:0] retrySel;
    logic [4:0] txRank;
    logic [6:0] payloadBytes;
    logic [5:0] slots;
    logic retryUnlimited;
    logic [1:0] retryMax;
  } cfc_fifo_s;

  typedef struct packed {
    logic [7:0] count;
  } cfc_cnt_s;

  // Depth field holds slots minus one
  function automatic logic [5:0] slot_count(input logic [4:0] sel);
    return {1'b0, sel} + 6'h01;
  endfunction

endpackage
`default_nettype wire

// ### design/cfc_err_counter.sv
// Saturating 8-bit error counter with software load
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defines.svh"

module cfc_err_counter (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic errPulse,
  input wire logic load,
  input wire logic [7:0] loadValue,
  output logic [7:0] count
);
  import cfc_pkg::*;

  cfc_cnt_s state;
  cfc_cnt_s next_state;

  // Software load beats a same-cycle error so a clear is exact
  always_comb begin
    next_state = state;
    if (load) begin
      next_state.count = loadValue;
    end else if (errPulse && state.count != `CFC_CNT_MAX) begin
      next_state.count = state.count + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '{count: `CFC_CNT_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_count_saturates: assert property (
    errPulse && !load && count == `CFC_CNT_MAX |=> count == `CFC_CNT_MAX)
    else $error("error counter wrapped past maximum");
  a_count_steps: assert property (
    errPulse && !load && count != `CFC_CNT_MAX |=> count == $past(count) + 8'h01)
    else $error("error counter missed an increment");
  a_count_loads: assert property (
    load |=> count == $past(loadValue))
    else $error("error counter did not take written value");
  c_count_full: cover property (errPulse && count == `CFC_CNT_MAX);

endmodule
`default_nettype wire

// ### design/cfc_fifo_cfg.sv
// One message FIFO control register with decoded outputs
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defines.svh"

module cfc_fifo_cfg (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic cfgMode,
  input wire logic retryEn,
  input wire logic [15:0] wrData,
  output logic [15:0] regValue,
  output logic [6:0] payloadBytes,
  output logic [5:0] slots,
  output logic retryUnlimited,
  output logic [1:0] retryMax,
  output logic [4:0] txRank
);
  import cfc_pkg::*;

  cfc_fifo_s state;
  cfc_fifo_s next_state;

  // Code 100 has no size of its own; it falls back to 8 bytes
  function automatic logic [6:0] payload_bytes(input logic [2:0] sel);
    case (sel)
      3'h1: return 7'h0C;
      3'h2: return 7'h10;
      3'h3: return 7'h14;
      3'h5: return 7'h20;
      3'h6: return 7'h30;
      3'h7: return 7'h40;
      default: return 7'h08;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    if (wrEn) begin
      next_state.retrySel = wrData[`CFC_FIFO_RTX_LSB +: 2];
      next_state.txRank = wrData[`CFC_FIFO_PRI_LSB +: 5];
      if (cfgMode) begin
        next_state.payloadSel = wrData[`CFC_FIFO_PL_LSB +: 3];
        next_state.depthSel = wrData[`CFC_FIFO_DEP_LSB +: 5];
      end
    end
    next_state.payloadBytes = payload_bytes(next_state.payloadSel);
    next_state.slots = slot_count(next_state.depthSel);
    // Limit only applies with the global enable; 10 treated as unlimited
    next_state.retryUnlimited = !retryEn ||
      next_state.retrySel[1];
    next_state.retryMax = (next_state.retrySel == `CFC_RTX_THREE) ?
      `CFC_RETRY_COUNT_THREE : 2'h0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '{payloadSel: 3'h0, depthSel: 5'h00,
                 retrySel: `CFC_RTX_RESET, txRank: 5'h00,
                 payloadBytes: 7'h08, slots: 6'h01,
                 retryUnlimited: 1'b1, retryMax: 2'h0};
    end else begin
      state <= next_state;
    end
  end

  assign regValue = {state.payloadSel, state.depthSel, 1'b0,
                     state.retrySel, state.txRank};
  assign payloadBytes = state.payloadBytes;
  assign slots = state.slots;
  assign retryUnlimited = state.retryUnlimited;
  assign retryMax = state.retryMax;
  assign txRank = state.txRank;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_depth_locked: assert property (
    wrEn && !cfgMode |=> $stable(regValue[15:8]))
    else $error("payload or depth changed outside configuration mode");
  a_slots_track: assert property (
    ##1 slots == {1'b0, regValue[12:8]} + 6'h01)
    else $error("slot count does not equal depth field plus one");
  a_payload_max: assert property (
    regValue[15:13] == 3'h7 |-> payloadBytes == 7'h40)
    else $error("payload code 111 does not give 64 bytes");

endmodule
`default_nettype wire

// ### design/cfc_top.sv
// CAN FIFO configuration and bus error counter registers behind APB
//
// Overview of operation
// - FIFO depth field gives field value plus one message slots
// - Transmit event FIFO depth sits in bits 12:8, value plus one
// - Retry field acts only with global enable; 11 unlimited, 01 three
// - Five-bit transmit rank per FIFO, 11111 highest, 00000 lowest
// - Payload and depth fields writable only in configuration mode 100
// - Fast-phase transmit error count in bits 15:8 of diagnostics high
// - Fast-phase receive error count in bits 7:0 of diagnostics high
// - Nominal transmit error count in bits 15:8 of diagnostics low
// - Nominal receive error count in bits 7:0 of diagnostics low
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defines.svh"

module cfc_top #(
  parameter int NUM_FIFO = 7,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nominalTxErr,
  input wire logic nominalRxErr,
  input wire logic fastPhaseTxErr,
  input wire logic fastPhaseRxErr,
  output logic [2:0] operatingMode,
  output logic configMode,
  output logic retryLimitEnable,
  output logic [5:0] tefSlots,
  output logic [NUM_FIFO*7-1:0] fifoPayloadBytes,
  output logic [NUM_FIFO*6-1:0] fifoSlots,
  output logic [NUM_FIFO-1:0] fifoRetryUnlimited,
  output logic [NUM_FIFO*2-1:0] fifoRetryMax,
  output logic [NUM_FIFO*5-1:0] fifoTxRank
);
  import cfc_pkg::*;

  if (NUM_FIFO < 1 || NUM_FIFO > 31) begin : g_bad_fifo
    $error("NUM_FIFO must lie between 1 and 31");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 32");
  end

  localparam int LAST_FIFO_OFF = 16 + 4 * NUM_FIFO;

  cfc_top_s state;
  cfc_top_s next_state;

  logic [7:0] fastTxCount;
  logic [7:0] fastRxCount;
  logic [7:0] nominalTxCount;
  logic [7:0] nominalRxCount;
  logic [15:0] fifoReg [NUM_FIFO];
  logic [NUM_FIFO-1:0] fifoWr;
  logic wrDone;
  logic wrDiagHi;
  logic wrDiagLo;

  // Word offset of the access, or all ones when misaligned
  function automatic logic [ADDR_W-1:0] word_off(
    input logic [ADDR_W-1:0] addr);
    return (addr[1:0] == 2'h0) ? addr : '1;
  endfunction

  // FIFO slot hit by an offset, NUM_FIFO when none
  function automatic int fifo_index(input logic [ADDR_W-1:0] off);
    int idx;
    idx = NUM_FIFO;
    for (int i = 0; i < NUM_FIFO; i++) begin
      if (off == ADDR_W'(16 + 4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // Writes land only on the edge that completes the access
  assign wrDone = psel && penable && state.pready && pwrite &&
                  !state.pslverr;
  assign wrDiagHi = wrDone &&
    word_off(paddr) == ADDR_W'(`CFC_OFF_DIAG_HI);
  assign wrDiagLo = wrDone &&
    word_off(paddr) == ADDR_W'(`CFC_OFF_DIAG_LO);

  always_comb begin
    logic [ADDR_W-1:0] off;
    int idx;
    logic hit;
    logic [15:0] rdWord;
    off = word_off(paddr);
    idx = fifo_index(off);
    hit = 1'b1;
    rdWord = 16'h0000;
    next_state = state;
    case (off)
      ADDR_W'(`CFC_OFF_CTRL): begin
        rdWord = {5'h00, state.opMode, 7'h00, state.retryEn};
      end
      ADDR_W'(`CFC_OFF_TEF): begin
        rdWord = {3'h0, state.tefDepthSel, 8'h00};
      end
      ADDR_W'(`CFC_OFF_DIAG_HI): begin
        rdWord = {fastTxCount, fastRxCount};
      end
      ADDR_W'(`CFC_OFF_DIAG_LO): begin
        rdWord = {nominalTxCount, nominalRxCount};
      end
      default: begin
        if (idx < NUM_FIFO) begin
          rdWord = fifoReg[idx];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
    unique case (state.phase)
      CFC_APB_IDLE: begin
        next_state.pready = 1'b0;
        if (psel && penable) begin
          next_state.phase = CFC_APB_RESP;
          next_state.pready = 1'b1;
          next_state.pslverr = !hit;
          next_state.prdata = (!pwrite && hit) ? {16'h0000, rdWord} :
                                                 32'h0000_0000;
        end
      end
      CFC_APB_RESP: begin
        next_state.phase = CFC_APB_IDLE;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
      end
    endcase
    if (wrDone && off == ADDR_W'(`CFC_OFF_CTRL)) begin
      next_state.opMode = pwdata[`CFC_CTRL_MODE_LSB +: 3];
      next_state.retryEn = pwdata[`CFC_CTRL_RTXEN_BIT];
    end
    // Depth is frozen outside configuration mode
    if (wrDone && off == ADDR_W'(`CFC_OFF_TEF) && state.cfgMode) begin
      next_state.tefDepthSel = pwdata[`CFC_TEF_DEP_LSB +: 5];
    end
    next_state.cfgMode = (next_state.opMode == `CFC_MODE_CONFIG);
    next_state.tefSlots = slot_count(next_state.tefDepthSel);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '{phase: CFC_APB_IDLE, pready: 1'b0, pslverr: 1'b0,
                 prdata: 32'h0000_0000, opMode: `CFC_MODE_RESET,
                 cfgMode: 1'b1, retryEn: 1'b0, tefDepthSel: 5'h00,
                 tefSlots: 6'h01};
    end else begin
      state <= next_state;
    end
  end

  for (genvar g = 0; g < NUM_FIFO; g++) begin : g_fifo
    assign fifoWr[g] = wrDone &&
      word_off(paddr) == ADDR_W'(`CFC_OFF_FIFO_BASE + 4 * g);
    cfc_fifo_cfg u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .wrEn(fifoWr[g]),
      .cfgMode(state.cfgMode),
      // Next enable, so decoded retry limits move on the same edge
      .retryEn(next_state.retryEn),
      .wrData(pwdata[15:0]),
      .regValue(fifoReg[g]),
      .payloadBytes(fifoPayloadBytes[g*7 +: 7]),
      .slots(fifoSlots[g*6 +: 6]),
      .retryUnlimited(fifoRetryUnlimited[g]),
      .retryMax(fifoRetryMax[g*2 +: 2]),
      .txRank(fifoTxRank[g*5 +: 5])
    );
  end

  // A software write wins over an error seen in the same cycle
  cfc_err_counter u_fast_tx (
    .clk_sys(clk_sys),
    .reset(reset),
    .errPulse(fastPhaseTxErr),
    .load(wrDiagHi),
    .loadValue(pwdata[`CFC_CNT_HI_LSB +: 8]),
    .count(fastTxCount)
  );
  cfc_err_counter u_fast_rx (
    .clk_sys(clk_sys),
    .reset(reset),
    .errPulse(fastPhaseRxErr),
    .load(wrDiagHi),
    .loadValue(pwdata[7:0]),
    .count(fastRxCount)
  );
  cfc_err_counter u_nom_tx (
    .clk_sys(clk_sys),
    .reset(reset),
    .errPulse(nominalTxErr),
    .load(wrDiagLo),
    .loadValue(pwdata[`CFC_CNT_HI_LSB +: 8]),
    .count(nominalTxCount)
  );
  cfc_err_counter u_nom_rx (
    .clk_sys(clk_sys),
    .reset(reset),
    .errPulse(nominalRxErr),
    .load(wrDiagLo),
    .loadValue(pwdata[7:0]),
    .count(nominalRxCount)
  );

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign operatingMode = state.opMode;
  assign configMode = state.cfgMode;
  assign retryLimitEnable = state.retryEn;
  assign tefSlots = state.tefSlots;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("access did not complete after one wait cycle");
  a_tef_locked: assert property (
    !configMode |=> $stable(state.tefDepthSel))
    else $error("event FIFO depth changed outside configuration mode");
  a_tef_slots: assert property (
    ##1 tefSlots == {1'b0, state.tefDepthSel} + 6'h01)
    else $error("event FIFO slots do not equal field plus one");
  a_retry_gated: assert property (
    ##1 !retryLimitEnable |-> fifoRetryUnlimited == '1)
    else $error("retry limit applied while globally disabled");
  a_retry_three: assert property (
    ##1 retryLimitEnable && $stable(retryLimitEnable) &&
    fifoReg[0][6:5] == `CFC_RTX_THREE |->
    fifoRetryMax[1:0] == 2'h3 && !fifoRetryUnlimited[0])
    else $error("retry code 01 did not give three attempts");
  a_rank_write: assert property (
    fifoWr[0] |=> fifoTxRank[4:0] == $past(pwdata[4:0]))
    else $error("transmit rank does not match its written field");
  a_diag_hi_read: assert property (
    psel && penable && !pready && !pwrite &&
    paddr == ADDR_W'(`CFC_OFF_DIAG_HI) |=>
    prdata == {16'h0000, $past(fastTxCount), $past(fastRxCount)})
    else $error("diagnostics high read returned wrong counts");
  a_diag_lo_read: assert property (
    psel && penable && !pready && !pwrite &&
    paddr == ADDR_W'(`CFC_OFF_DIAG_LO) |=>
    prdata == {16'h0000, $past(nominalTxCount), $past(nominalRxCount)})
    else $error("diagnostics low read returned wrong counts");
  a_unmapped_error: assert property (
    psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not flagged as slave error");

  // Field writes land where they are addressed, and only then
  a_mode_write: assert property (
    wrDone && paddr == ADDR_W'(`CFC_OFF_CTRL) |=>
    operatingMode == $past(pwdata[`CFC_CTRL_MODE_LSB +: 3]))
    else $error("operating mode did not take the written value");
  a_fifo_write: assert property (
    fifoWr[0] && configMode |=>
    fifoReg[0][15:8] == $past(pwdata[15:8]))
    else $error("size fields ignored a write in configuration mode");
  a_fifo_lock: assert property (
    fifoWr[0] && !configMode |=>
    fifoReg[0][15:8] == $past(fifoReg[0][15:8]))
    else $error("size fields took a write outside configuration mode");
  a_tef_write: assert property (
    wrDone && configMode && paddr == ADDR_W'(`CFC_OFF_TEF) |=>
    tefSlots == {1'b0, $past(pwdata[12:8])} + 6'h01)
    else $error("event FIFO depth did not take the written value");
  a_last_slots: assert property (
    fifoWr[NUM_FIFO-1] && configMode |=>
    fifoSlots[NUM_FIFO*6-1 -: 6] == {1'b0, $past(pwdata[12:8])} + 6'h01)
    else $error("last FIFO slot count does not equal depth plus one");

  // Retry codes set a limit only while the global limit is enabled; 11 is unlimited either way
  a_retry_none: assert property (
    ##1 retryLimitEnable && fifoReg[0][6:5] == `CFC_RTX_NONE |->
    fifoRetryMax[1:0] == 2'h0 && !fifoRetryUnlimited[0])
    else $error("retry code 00 still allowed retransmissions");
  a_retry_unlimited: assert property (
    ##1 fifoReg[0][6:5] == `CFC_RTX_UNLIMITED |-> fifoRetryUnlimited[0])
    else $error("retry code 11 applied a limit");

  // Bus answers: one-cycle ready, errors only with ready
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready stood for more than one cycle");
  a_error_with_ready: assert property (
    pslverr |-> pready)
    else $error("slave error shown without ready");
  a_idle_no_ready: assert property (
    !psel |=> !pready)
    else $error("ready raised without a selected access");
  a_write_no_data: assert property (
    psel && penable && !pready && pwrite |=> prdata == 32'h0000_0000)
    else $error("write access returned nonzero read data");
  a_past_last_fifo: assert property (
    psel && penable && !pready && paddr >= ADDR_W'(LAST_FIFO_OFF) |=>
    pslverr)
    else $error("access beyond the last FIFO not flagged");
  a_error_ignored: assert property (
    psel && penable && pready && pslverr |=>
    $stable(operatingMode) && $stable(tefSlots))
    else $error("refused access changed a register");

  // Reads return the fields where the register map places them
  a_ctrl_read: assert property (
    psel && penable && !pready && !pwrite &&
    paddr == ADDR_W'(`CFC_OFF_CTRL) |=>
    prdata == {21'h00_0000, $past(operatingMode), 7'h00,
               $past(retryLimitEnable)})
    else $error("control read returned wrong fields");
  a_tef_read: assert property (
    psel && penable && !pready && !pwrite &&
    paddr == ADDR_W'(`CFC_OFF_TEF) |=>
    prdata == {19'h0_0000, $past(state.tefDepthSel), 8'h00})
    else $error("event FIFO read returned wrong fields");

  // A diagnostics write loads both of its counters
  a_diag_hi_load: assert property (
    wrDiagHi |=> fastTxCount == $past(pwdata[15:8]) &&
    fastRxCount == $past(pwdata[7:0]))
    else $error("diagnostics high write did not load its counters");
  a_diag_lo_load: assert property (
    wrDiagLo |=> nominalTxCount == $past(pwdata[15:8]) &&
    nominalRxCount == $past(pwdata[7:0]))
    else $error("diagnostics low write did not load its counters");

  c_cfg_write: cover property (wrDone && configMode);
  c_locked_write: cover property (fifoWr[0] && !configMode);
  c_diag_load: cover property (wrDiagLo ##1 nominalRxErr);
  c_slave_error: cover property (pready && pslverr);

endmodule
`default_nettype wire

// ### dv/cfc_err_src.sv
// Error event source standing in for the bus-side frame engine
`timescale 1ns/1ps
`default_nettype none
module cfc_err_src (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic [3:0] sel,
  input wire logic [8:0] n,
  output logic [3:0] errPulse,
  output logic busy
);
  logic [8:0] left;
  logic [3:0] mask;
  // One event per cycle on each selected line, as same-clock logic would
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      left <= 9'h000;
      mask <= 4'h0;
    end else if (start) begin
      left <= n;
      mask <= sel;
    end else if (left != 9'h000) begin
      left <= left - 9'h001;
    end
  end
  assign errPulse = (left != 9'h000) ? mask : 4'h0;
  assign busy = start || (left != 9'h000);
endmodule
`default_nettype wire

// ### dv/can_fifo_config_and_error_counters_tb_top.sv
// Self-checking bench for the CAN FIFO configuration registers
`timescale 1ns/1ps
`default_nettype none
module can_fifo_config_and_error_counters_tb_top;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdExp;
    logic errExp;
  } cfc_row_s;
  logic clk_sys, reset, psel, penable, pwrite, start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, configMode, retryLimitEnable, busy;
  logic [2:0] operatingMode;
  logic [5:0] tefSlots;
  logic [48:0] fifoPayloadBytes;
  logic [41:0] fifoSlots;
  logic [6:0] fifoRetryUnlimited;
  logic [13:0] fifoRetryMax;
  logic [34:0] fifoTxRank;
  logic [3:0] errPulse, sel;
  logic [8:0] n;
  logic [15:0] v;
  int num_errors, n_compared, cycles;
  cfc_row_s rows[8];
  logic [6:0] plBytes[8];

  cfc_top DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nominalTxErr(errPulse[0]), .nominalRxErr(errPulse[1]),
    .fastPhaseTxErr(errPulse[2]), .fastPhaseRxErr(errPulse[3]),
    .operatingMode(operatingMode), .configMode(configMode),
    .retryLimitEnable(retryLimitEnable), .tefSlots(tefSlots),
    .fifoPayloadBytes(fifoPayloadBytes), .fifoSlots(fifoSlots),
    .fifoRetryUnlimited(fifoRetryUnlimited), .fifoRetryMax(fifoRetryMax),
    .fifoTxRank(fifoTxRank));

  cfc_err_src PARTNER (.clk_sys(clk_sys), .reset(reset), .start(start),
    .sel(sel), .n(n), .errPulse(errPulse), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; generous ceiling
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Idle cycle first so psel never toggles twice in one time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write, then let the decoded outputs settle before looking at them
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge clk_sys);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  task automatic pulse(input logic [3:0] s, input logic [8:0] k);
    @(posedge clk_sys);
    sel <= s;
    n <= k;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    while (busy === 1'b1) @(posedge clk_sys);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    start = 1'b0;
    sel = 4'h0;
    n = 9'h000;
    plBytes = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h08, 7'h20, 7'h30, 7'h40};
    rows[0] = '{12'h000, 32'h0000_0401, 32'h0000_0401, 1'b0};
    rows[1] = '{12'h004, 32'h0000_1FFF, 32'h0000_1F00, 1'b0};
    rows[2] = '{12'h010, 32'h0000_FFFF, 32'h0000_FF7F, 1'b0};
    rows[3] = '{12'h008, 32'h0000_A55A, 32'h0000_A55A, 1'b0};
    rows[4] = '{12'h00C, 32'h0000_5AA5, 32'h0000_5AA5, 1'b0};
    rows[5] = '{12'h02C, 32'h0000_1234, 32'h0000_0000, 1'b1};
    rows[6] = '{12'h002, 32'h0000_1234, 32'h0000_0000, 1'b1};
    rows[7] = '{12'h028, 32'h0000_FFFF, 32'h0000_FF7F, 1'b0};
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      check(32'(err), 32'(rows[i].errExp));
      rdchk(rows[i].addr, rows[i].rdExp);
      check(32'(err), 32'(rows[i].errExp));
    end
    check(32'(tefSlots), 32'h0000_0020);
    check(32'(fifoSlots[5:0]), 32'h0000_0020);
    check(32'(fifoTxRank[4:0]), 32'h0000_001F);
    check(32'(fifoSlots[41:36]), 32'h0000_0020);
    check(32'(fifoPayloadBytes[48:42]), 32'h0000_0040);
    check(32'(fifoTxRank[34:30]), 32'h0000_001F);
    check(32'(fifoRetryUnlimited[6]), 32'h0000_0001);
    check(32'(fifoRetryMax[13:12]), 32'h0000_0000);
    $display("test register rows done");

    for (int c = 0; c < 8; c++) begin
      v = {c[2:0], 5'(c), 1'b0, c[1:0], 5'(c * 4 + 3)};
      wr(12'h010, {16'h0000, v});
      check(32'(fifoPayloadBytes[6:0]), 32'(plBytes[c]));
      check(32'(fifoSlots[5:0]), 32'(c + 1));
      check(32'(fifoTxRank[4:0]), 32'(c * 4 + 3));
      check(32'(fifoRetryUnlimited[0]), 32'(c[1]));
      if (!c[1]) begin
        check(32'(fifoRetryMax[1:0]), c[0] ? 32'h3 : 32'h0);
      end
    end
    $display("test field decode done");

    // Retry field has no effect while the global enable is clear
    wr(12'h000, 32'h0000_0400);
    wr(12'h010, 32'h0000_0000);
    check(32'(fifoRetryUnlimited[0]), 32'h0000_0001);
    wr(12'h000, 32'h0000_0401);
    check(32'(retryLimitEnable), 32'h0000_0001);
    check(32'(fifoRetryUnlimited[0]), 32'h0000_0000);
    check(32'(fifoRetryMax[1:0]), 32'h0000_0000);
    $display("test retry enable done");

    // Leave configuration mode: size fields lock, the rest still writes
    wr(12'h000, 32'h0000_0001);
    check(32'(configMode), 32'h0000_0000);
    wr(12'h010, 32'h0000_FFFF);
    rdchk(12'h010, 32'h0000_007F);
    wr(12'h004, 32'h0000_0000);
    rdchk(12'h004, 32'h0000_1F00);
    wr(12'h000, 32'h0000_0401);
    check(32'(operatingMode), 32'h0000_0004);
    wr(12'h010, 32'h0000_E000);
    rdchk(12'h010, 32'h0000_E000);
    $display("test mode lock done");

    wr(12'h00C, 32'h0000_0000);
    pulse(4'h1, 9'h003);
    rdchk(12'h00C, 32'h0000_0300);
    pulse(4'h2, 9'h002);
    rdchk(12'h00C, 32'h0000_0302);
    wr(12'h008, 32'h0000_FDFE);
    pulse(4'hC, 9'h004);
    rdchk(12'h008, 32'h0000_FFFF);
    $display("test error counters done");

    // Second reset in mid-run must bring control, event FIFO, both diagnostics and FIFO 0 fields back
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk(12'h010, 32'h0000_0060);
    rdchk(12'h000, 32'h0000_0400);
    rdchk(12'h004, 32'h0000_0000);
    rdchk(12'h008, 32'h0000_0000);
    rdchk(12'h00C, 32'h0000_0000);
    check(32'(tefSlots), 32'h0000_0001);
    check(32'(configMode), 32'h0000_0001);
    $display("test reset values done");
    end_of_test();
  end
endmodule
`default_nettype wire
